// File: design/effective_address_generation.sv
// Instruction fetch and effective address generation with a Wishbone register port
// Functional notes
// - Word address is low fifteen instruction bits
// - Indexing adds selected index register to address
// - Indirect replaces low eighteen bits from storage
// - Character address is instruction bits 00-16
// - Character address splits into word and position
// - Executive mode appends three extra character address bits
// - No indirect for character instructions; limited indexing
// - Character indexing uses fixed predetermined index register
// - Business opcodes 64-67 fetch three consecutive words
// - Business word addressing uses bits 02-16
// - Non-business character address adds designated index
// - Field C address adds index chosen by flag
// - Word to character: shift two, add position
// - Character to word: quotient and remainder by four
// - Register number field selects file entry 00-77
// - Seven-bit field addresses page index file
// - Immediate word format: low fifteen bits operand
// - Immediate character format: low seventeen bits operand
// - Search instructions carry six-bit comparison character
// - Fetch performs one to three instruction reads
// - Bit 17 selects direct or indirect addressing
// - Bits 15-16 select index register for words
// - Indirect repeats until fetched bit 17 is zero
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/10ps
`include "eag_defines.svh"
module effective_address_generation
	import eag_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone register port
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Storage read port
	output logic             mem_stb_o,
	output logic      [14:0] mem_adr_o,
	input  wire logic [23:0] mem_dat_i,
	input  wire logic        mem_ack_i,
	// Status
	output logic             busy_o
);

	state_t      st_q;
	logic [2:0]  fmt_q;
	logic        exec_q;
	logic [1:0]  fixidx_q;
	logic [2:0]  ext_q;
	logic [14:0] paddr_q;
	logic [16:0] idx_q [1:3];
	iword_t      iw_q [0:2];
	logic [1:0]  cnt_q;
	logic        bsn_q;
	logic [7:0]  lvl_q;
	logic        done_q;
	logic [14:0] rword_q;
	logic [1:0]  rpos_q;
	logic [19:0] rchar_q;
	logic [19:0] rfc_q;
	logic [16:0] roper_q;
	logic        ack_q;
	logic [31:0] dat_q;
	logic        mem_stb_q;
	logic [14:0] mem_adr_q;
	logic        busy_q;

	addr_conv_if cv ();

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask,
		input logic [31:0] data);
		merge = (old & ~mask) | (data & mask);
	endfunction

	function automatic logic [16:0] idx_val(input logic [1:0] sel, input logic [16:0] b1,
		input logic [16:0] b2, input logic [16:0] b3);
		// Designator zero means no index register
		idx_val = (sel == 2'h1) ? b1 : (sel == 2'h2) ? b2 : (sel == 2'h3) ? b3 : 17'h00000;
	endfunction

	// Bus decode
	wire        bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
	wire        bus_wr    = bus_req & wb_we_i;
	wire [31:0] wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire        sel_ctrl  = wb_adr_i == `EAG_OFF_CTRL;
	wire        sel_paddr = wb_adr_i == `EAG_OFF_PADDR;
	wire        sel_idx1  = wb_adr_i == `EAG_OFF_IDX1;
	wire        sel_idx2  = wb_adr_i == `EAG_OFF_IDX2;
	wire        sel_idx3  = wb_adr_i == `EAG_OFF_IDX3;
	wire        idle      = st_q == S_IDLE;
	// Setup registers are frozen while a decode runs so it sees one consistent context
	wire        wr_ok     = bus_wr & idle;

	wire [31:0] ctrl_rd   = {22'h000000, ext_q, fixidx_q, exec_q, fmt_q, 1'b0};
	wire [31:0] ctrl_new  = merge(ctrl_rd, wmask, wb_dat_i);
	wire [31:0] paddr_new = merge({17'h00000, paddr_q}, wmask, wb_dat_i);
	wire [31:0] idx1_new  = merge({15'h0000, idx_q[1]}, wmask, wb_dat_i);
	wire [31:0] idx2_new  = merge({15'h0000, idx_q[2]}, wmask, wb_dat_i);
	wire [31:0] idx3_new  = merge({15'h0000, idx_q[3]}, wmask, wb_dat_i);
	wire        start     = wr_ok & sel_ctrl & ctrl_new[`EAG_CTRL_START];

	// Instruction field views
	wire [5:0]  regnum    = iw_q[0][`EAG_REGNUM];
	wire [6:0]  pageidx   = iw_q[0][`EAG_PAGEIDX];
	wire [5:0]  schar     = iw_q[0][`EAG_SCHAR];

	wire [31:0] rd_data =
		sel_ctrl  ? ctrl_rd :
		sel_paddr ? {17'h00000, paddr_q} :
		sel_idx1  ? {15'h0000, idx_q[1]} :
		sel_idx2  ? {15'h0000, idx_q[2]} :
		sel_idx3  ? {15'h0000, idx_q[3]} :
		(wb_adr_i == `EAG_OFF_STATUS)  ? {19'h00000, lvl_q, cnt_q, bsn_q, done_q, ~idle} :
		(wb_adr_i == `EAG_OFF_INSTR0)  ? {8'h00, iw_q[0]} :
		(wb_adr_i == `EAG_OFF_INSTR1)  ? {8'h00, iw_q[1]} :
		(wb_adr_i == `EAG_OFF_INSTR2)  ? {8'h00, iw_q[2]} :
		(wb_adr_i == `EAG_OFF_RWORD)   ? {15'h0000, rpos_q, rword_q} :
		(wb_adr_i == `EAG_OFF_RCHAR)   ? {12'h000, rchar_q} :
		(wb_adr_i == `EAG_OFF_RFIELDC) ? {12'h000, rfc_q} :
		(wb_adr_i == `EAG_OFF_ROPER)   ? {15'h0000, roper_q} :
		(wb_adr_i == `EAG_OFF_RFIELDS) ? {13'h0000, schar, pageidx, regnum} :
		32'h00000000;

	// Fetch decisions
	wire        op_bsn    = (mem_dat_i[`EAG_OPCODE] >= `EAG_BSN_OP_LO) &&
	                        (mem_dat_i[`EAG_OPCODE] <= `EAG_BSN_OP_HI);
	wire        is_bsn    = (cnt_q == 2'h0) ? op_bsn : bsn_q;
	wire        last_word = (cnt_q == 2'h2) | ~is_bsn;
	wire [23:0] word0     = (cnt_q == 2'h0) ? mem_dat_i : iw_q[0];
	// Only plain word-addressed instructions may go indirect
	wire        go_indir  = (fmt_q == FMT_WORD) & ~is_bsn & word0[`EAG_AMODE];

	// Address arithmetic
	wire        is_char   = (fmt_q == FMT_CHAR) | (fmt_q == FMT_CHAR_IDX);
	wire [2:0]  ext_app   = exec_q ? ext_q : 3'h0;
	wire [16:0] widx      = idx_val(iw_q[0][`EAG_BDESIG], idx_q[1], idx_q[2], idx_q[3]);
	wire [16:0] fixed_idx = idx_val(fixidx_q, idx_q[1], idx_q[2], idx_q[3]);
	wire [16:0] rflag_idx = idx_val(iw_q[1][`EAG_BFLAG], idx_q[1], idx_q[2], idx_q[3]);
	wire [16:0] sflag_idx = idx_val(iw_q[2][`EAG_BFLAG], idx_q[1], idx_q[2], idx_q[3]);
	wire [16:0] r_base    = bsn_q ? iw_q[1][`EAG_CADDR] : iw_q[0][`EAG_CADDR];
	wire [16:0] r_index   = bsn_q ? rflag_idx :
	                        (fmt_q == FMT_CHAR_IDX) ? fixed_idx : 17'h00000;
	wire [14:0] wsum;
	wire [16:0] rsum;
	wire [16:0] ssum;
	wire [14:0] word_eff  = bsn_q ? iw_q[1][`EAG_CWORD] : wsum;

	index_adder #(.W(15)) u_word_add (
		.base_i  (iw_q[0][`EAG_WADDR]),
		.index_i (widx[14:0]),
		.sum_o   (wsum)
	);

	index_adder #(.W(17)) u_char_add (
		.base_i  (r_base),
		.index_i (r_index),
		.sum_o   (rsum)
	);

	index_adder #(.W(17)) u_fieldc_add (
		.base_i  (iw_q[2][`EAG_CADDR]),
		.index_i (sflag_idx),
		.sum_o   (ssum)
	);

	assign cv.w2c_word = word_eff;
	assign cv.w2c_pos  = 2'b00;
	assign cv.c2w_char = rsum;

	addr_convert u_conv (
		.cv (cv)
	);

	// Register port
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= bus_req;
			if (bus_req) begin
				dat_q <= rd_data;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fmt_q    <= `EAG_FMT_RST;
			exec_q   <= 1'b0;
			fixidx_q <= `EAG_FIXIDX_RST;
			ext_q    <= `EAG_EXT_RST;
			paddr_q  <= `EAG_PADDR_RST;
		end else if (wr_ok) begin
			if (sel_ctrl) begin
				fmt_q    <= ctrl_new[`EAG_CTRL_FMT];
				exec_q   <= ctrl_new[`EAG_CTRL_EXEC];
				fixidx_q <= ctrl_new[`EAG_CTRL_FIXIDX];
				ext_q    <= ctrl_new[`EAG_CTRL_EXT];
			end
			if (sel_paddr) begin
				paddr_q <= paddr_new[14:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idx_q[1] <= `EAG_IDX_RST;
			idx_q[2] <= `EAG_IDX_RST;
			idx_q[3] <= `EAG_IDX_RST;
		end else if (wr_ok) begin
			if (sel_idx1) begin
				idx_q[1] <= idx1_new[16:0];
			end
			if (sel_idx2) begin
				idx_q[2] <= idx2_new[16:0];
			end
			if (sel_idx3) begin
				idx_q[3] <= idx3_new[16:0];
			end
		end
	end

	// Fetch and indirect sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q      <= S_IDLE;
			mem_stb_q <= 1'b0;
			mem_adr_q <= 15'h0000;
			cnt_q     <= 2'h0;
			bsn_q     <= 1'b0;
			lvl_q     <= 8'h00;
			done_q    <= 1'b0;
			iw_q[0]   <= 24'h000000;
			iw_q[1]   <= 24'h000000;
			iw_q[2]   <= 24'h000000;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					if (start) begin
						st_q      <= S_FETCH;
						mem_stb_q <= 1'b1;
						mem_adr_q <= paddr_q;
						cnt_q     <= 2'h0;
						bsn_q     <= 1'b0;
						lvl_q     <= 8'h00;
						done_q    <= 1'b0;
					end
				end
				S_FETCH: begin
					// Strobe drops for a cycle after each answer that another read follows
					if (!mem_stb_q) begin
						mem_stb_q <= 1'b1;
					end else if (mem_ack_i) begin
						mem_stb_q   <= 1'b0;
						iw_q[cnt_q] <= mem_dat_i;
						cnt_q       <= cnt_q + 2'h1;
						bsn_q       <= is_bsn;
						if (!last_word) begin
							mem_adr_q <= mem_adr_q + 15'h0001;
						end else if (go_indir) begin
							st_q      <= S_INDIR;
							mem_adr_q <= word0[`EAG_WADDR];
						end else begin
							st_q <= S_CALC;
						end
					end
				end
				S_INDIR: begin
					if (!mem_stb_q) begin
						mem_stb_q <= 1'b1;
					end else if (mem_ack_i) begin
						mem_stb_q      <= 1'b0;
						iw_q[0][17:0]  <= mem_dat_i[17:0];
						lvl_q          <= (lvl_q == 8'hFF) ? lvl_q : lvl_q + 8'h01;
						if (mem_dat_i[`EAG_AMODE]) begin
							mem_adr_q <= mem_dat_i[`EAG_WADDR];
						end else begin
							st_q <= S_CALC;
						end
					end
				end
				S_CALC: begin
					st_q   <= S_IDLE;
					done_q <= 1'b1;
				end
				default: begin
					st_q      <= S_IDLE;
					mem_stb_q <= 1'b0;
				end
			endcase
		end
	end

	// Result capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rword_q <= 15'h0000;
			rpos_q  <= 2'h0;
			rchar_q <= 20'h00000;
			rfc_q   <= 20'h00000;
			roper_q <= 17'h00000;
			busy_q  <= 1'b0;
		end else begin
			busy_q <= ~idle | start;
			if (st_q == S_CALC) begin
				if (is_char) begin
					rword_q <= cv.c2w_word;
					rpos_q  <= cv.c2w_pos;
					rchar_q <= {ext_app, rsum};
				end else begin
					rword_q <= word_eff;
					rpos_q  <= 2'h0;
					rchar_q <= {3'h0, cv.w2c_char};
				end
				rfc_q   <= bsn_q ? {ext_app, ssum} : 20'h00000;
				roper_q <= (fmt_q == FMT_IMM_WORD) ? {2'b00, iw_q[0][`EAG_WADDR]} :
				           (fmt_q == FMT_IMM_CHAR) ? iw_q[0][`EAG_CADDR] :
				           17'h00000;
			end
		end
	end

	assign wb_ack_o  = ack_q;
	assign wb_dat_o  = dat_q;
	assign mem_stb_o = mem_stb_q;
	assign mem_adr_o = mem_adr_q;
	assign busy_o    = busy_q;

endmodule

// File: design/eag_defines.svh
// Register offsets, field positions and reset values of the address generator
`ifndef EAG_DEFINES_SVH
`define EAG_DEFINES_SVH

`define EAG_OFF_CTRL    8'h00
`define EAG_OFF_PADDR   8'h04
`define EAG_OFF_IDX1    8'h08
`define EAG_OFF_IDX2    8'h0C
`define EAG_OFF_IDX3    8'h10
`define EAG_OFF_STATUS  8'h14
`define EAG_OFF_INSTR0  8'h18
`define EAG_OFF_INSTR1  8'h1C
`define EAG_OFF_INSTR2  8'h20
`define EAG_OFF_RWORD   8'h24
`define EAG_OFF_RCHAR   8'h28
`define EAG_OFF_RFIELDC 8'h2C
`define EAG_OFF_ROPER   8'h30
`define EAG_OFF_RFIELDS 8'h34

`define EAG_CTRL_START  0
`define EAG_CTRL_FMT    3:1
`define EAG_CTRL_EXEC   4
`define EAG_CTRL_FIXIDX 6:5
`define EAG_CTRL_EXT    9:7

`define EAG_FMT_RST     3'h0
`define EAG_FIXIDX_RST  2'h1
`define EAG_EXT_RST     3'h0
`define EAG_PADDR_RST   15'h0000
`define EAG_IDX_RST     17'h00000

`define EAG_OPCODE      23:18
`define EAG_BSN_OP_LO   6'h34
`define EAG_BSN_OP_HI   6'h37
`define EAG_AMODE       17
`define EAG_BDESIG      16:15
`define EAG_WADDR       14:0
`define EAG_CADDR       16:0
`define EAG_CWORD       16:2
`define EAG_CPOS        1:0
`define EAG_BFLAG       18:17
`define EAG_REGNUM      5:0
`define EAG_PAGEIDX     6:0
`define EAG_SCHAR       11:6

`endif

// File: design/eag_pkg.sv
// Types shared by the address generator modules
package eag_pkg;

	typedef enum logic [3:0] {
		S_IDLE  = 4'h1,
		S_FETCH = 4'h2,
		S_INDIR = 4'h4,
		S_CALC  = 4'h8
	} state_t;

	typedef enum logic [2:0] {
		FMT_WORD     = 3'h0,
		FMT_CHAR     = 3'h1,
		FMT_CHAR_IDX = 3'h2,
		FMT_IMM_WORD = 3'h3,
		FMT_IMM_CHAR = 3'h4
	} fmt_t;

	typedef logic [23:0] iword_t;

endpackage

// File: design/addr_conv_if.sv
// Word/character address conversion signals between generator and converter
`timescale 1ns/10ps
interface addr_conv_if;
	logic [14:0] w2c_word;
	logic [1:0]  w2c_pos;
	logic [16:0] w2c_char;
	logic [16:0] c2w_char;
	logic [14:0] c2w_word;
	logic [1:0]  c2w_pos;

	modport conv (
		input  w2c_word,
		input  w2c_pos,
		input  c2w_char,
		output w2c_char,
		output c2w_word,
		output c2w_pos
	);
	modport user (
		output w2c_word,
		output w2c_pos,
		output c2w_char,
		input  w2c_char,
		input  c2w_word,
		input  c2w_pos
	);
endinterface

// File: design/index_adder.sv
// Index addition at the width of the address field being modified
`timescale 1ns/10ps
module index_adder #(
	parameter int W = 15
) (
	input  wire logic [W-1:0] base_i,
	input  wire logic [W-1:0] index_i,
	output logic      [W-1:0] sum_o
);
	// Carry out of the top bit is dropped, so addresses wrap
	assign sum_o = base_i + index_i;
endmodule

// File: design/addr_convert.sv
// Conversion between word address plus position and character address
`timescale 1ns/10ps
module addr_convert (
	addr_conv_if.conv cv
);
	assign cv.w2c_char = {cv.w2c_word, 2'b00} + {15'h0000, cv.w2c_pos};
	assign cv.c2w_word = cv.c2w_char[16:2];
	assign cv.c2w_pos  = cv.c2w_char[1:0];
endmodule

// File: tb/eag_mem_model.sv
// Storage model answering reads after a set number of wait cycles
`timescale 1ns/10ps
module eag_mem_model (
	// Clock and answer delay
	input  wire logic        clk_i,
	input  wire logic [3:0]  lag_i,
	// Read port
	input  wire logic        stb_i,
	input  wire logic [14:0] adr_i,
	output logic      [23:0] dat_o,
	output logic             ack_o
);
	logic [23:0] mem [0:32767];
	logic [3:0]  cnt_q = 4'h0;
	// Data flips outside an answer so a stale word is never read as fresh
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		dat_o <= ~dat_o;
		cnt_q <= 4'h0;
		if (stb_i && !ack_o) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q >= lag_i) begin
				ack_o <= 1'b1;
				dat_o <= mem[adr_i];
			end
		end
	end
endmodule

// File: tb/eag_chk.sv
// Handshake assertions for the address generator
`timescale 1ns/10ps
module eag_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        mem_stb_o,
	input wire logic [14:0] mem_adr_o,
	input wire logic        mem_ack_i,
	input wire logic        busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	sequence s_start;
		req && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[0] && !busy_o;
	endsequence
	sequence s_fetch;
		busy_o && mem_stb_o;
	endsequence
	chk_ack_one_cycle: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse");
	chk_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	chk_start_fetch: assert property (s_start |=> s_fetch)
		else $error("start did not raise a fetch");
	chk_fetch_hold: assert property (mem_stb_o && !mem_ack_i |=> mem_stb_o && $stable(mem_adr_o))
		else $error("read request changed before answer");
	chk_fetch_drop: assert property (mem_stb_o && mem_ack_i |=> !mem_stb_o)
		else $error("read request held after answer");
	chk_fetch_busy: assert property (mem_stb_o |-> busy_o)
		else $error("read request while idle");
	chk_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !mem_stb_o && !busy_o)
		else $error("outputs active after reset");
	chk_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i > 8'h34 |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind effective_address_generation eag_chk u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_stb_o(mem_stb_o),
	.mem_adr_o(mem_adr_o), .mem_ack_i(mem_ack_i), .busy_o(busy_o)
);

// File: tb/testbench.sv
// Self-checking bench for the address generator
`timescale 1ns/10ps
module testbench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [7:0]  adr   = 8'h00;
	logic [3:0]  sel   = 4'hF;
	logic [3:0]  msk   = 4'hF;
	logic [31:0] wd    = 32'h0;
	logic [3:0]  lag   = 4'h0;
	logic [31:0] rdat;
	logic [31:0] rd_q;
	logic        ack;
	logic        mstb;
	logic        mack;
	logic        busy;
	logic [14:0] madr;
	logic [23:0] mdat;
	logic [16:0] ix [0:3];
	logic [23:0] w;
	logic [23:0] w1;
	logic [23:0] w2;
	logic [16:0] t;
	int          miscompares = 0;
	int          comparisons = 0;
	int          seed        = 92160;
	int          i;
	always #5 clk_i = ~clk_i;
	effective_address_generation u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
		.mem_stb_o(mstb), .mem_adr_o(madr), .mem_dat_i(mdat), .mem_ack_i(mack),
		.busy_o(busy)
	);
	eag_mem_model u_mem (
		.clk_i(clk_i), .lag_i(lag), .stb_i(mstb), .adr_i(madr), .dat_o(mdat), .ack_o(mack)
	);
	function automatic logic [16:0] xv(input logic [1:0] b);
		return (b == 2'h0) ? 17'h0 : ix[b];
	endfunction
	task automatic wrap_up;
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch reg %h expected %h seen %h", a, exp, got);
		end
	endtask
	// Request held until ack is seen at a rising edge, then released
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		wd <= d;
		sel <= msk;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20)
			chk(a, 32'h0, 32'h1);
		if (n >= 20)
			wrap_up();
		rd_q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(a, rd_q & m, e);
	endtask
	task automatic run(input logic [14:0] p, input logic [31:0] c);
		int n;
		xfer(1'b1, 8'h04, {17'h0, p});
		xfer(1'b1, 8'h00, c);
		for (n = 0; busy !== 1'b0; n++) begin
			if (n > 400)
				chk(8'h14, 32'h0, 32'h1);
			if (n > 400)
				wrap_up();
			@(posedge clk_i);
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(8'h00, 32'hFFFFFFFF, 32'h20);
		xfer(1'b1, 8'h14, 32'hFFFF);
		rdc(8'h14, 32'hFFFFFFFF, 32'h0);
		rdc(8'hFC, 32'hFFFFFFFF, 32'h0);
		for (i = 1; i < 4; i++) begin
			ix[i] = 17'($random(seed));
			xfer(1'b1, 8'(4 * i + 4), {15'h0, ix[i]});
		end
		msk = 4'h1;
		xfer(1'b1, 8'h08, 32'hFF);
		msk = 4'hF;
		ix[1][7:0] = 8'hFF;
		rdc(8'h08, 32'h1FFFF, {15'h0, ix[1]});
		for (i = 0; i < 6; i++) begin
			// Opcode kept below the business range and bit 17 clear
			w = 24'($random(seed)) & 24'h3DFFFF;
			if (i == 0)
				w[16:0] = 17'h1FFFF;
			lag <= 4'($random(seed)) & 4'h7;
			u_mem.mem[15'(i * 977)] = w;
			run(15'(i * 977), 32'h21);
			t = xv(w[16:15]);
			rdc(8'h24, 32'h7FFF, {17'h0, 15'(w[14:0] + t[14:0])});
			rdc(8'h28, 32'hFFFFF, {15'h0, 15'(w[14:0] + t[14:0]), 2'h0});
			rdc(8'h14, 32'h1FFF, 32'hA);
		end
		w = {6'h01, 1'b1, 2'h0, 15'h2000};
		w1 = {6'h2A, 1'b1, 2'h1, 15'h7FFF};
		w2 = {6'h15, 1'b0, 2'h2, 15'($random(seed))};
		u_mem.mem[15'h0100] = w;
		u_mem.mem[15'h2000] = w1;
		u_mem.mem[15'h7FFF] = w2;
		run(15'h0100, 32'h21);
		rdc(8'h18, 32'hFFFFFF, {8'h0, w[23:18], w2[17:0]});
		rdc(8'h14, 32'h1FFF, 32'h4A);
		rdc(8'h24, 32'h7FFF, {17'h0, 15'(w2[14:0] + ix[2][14:0])});
		w = 24'($random(seed)) & 24'h3FFFFF | 24'h020000;
		u_mem.mem[15'h0200] = w;
		run(15'h0200, 32'h2B3);
		rdc(8'h28, 32'hFFFFF, {12'h0, 3'h5, w[16:0]});
		rdc(8'h24, 32'h1FFFF, {15'h0, w[1:0], w[16:2]});
		rdc(8'h14, 32'h1FFF, 32'hA);
		run(15'h0200, 32'h45);
		rdc(8'h28, 32'hFFFFF, {15'h0, 17'(w[16:0] + ix[2])});
		run(15'h0200, 32'h27);
		rdc(8'h30, 32'h1FFFF, {17'h0, w[14:0]});
		run(15'h0200, 32'h29);
		rdc(8'h30, 32'h1FFFF, {15'h0, w[16:0]});
		rdc(8'h34, 32'h7FFFF, {13'h0, w[11:6], w[6:0], w[5:0]});
		for (i = 0; i < 4; i++) begin
			w = {6'h34 + 6'(i), 18'($random(seed))};
			w1 = 24'($random(seed));
			w2 = 24'($random(seed));
			u_mem.mem[15'h7FFE] = w;
			u_mem.mem[15'h7FFF] = w1;
			u_mem.mem[15'h0000] = w2;
			run(15'h7FFE, 32'h21);
			t = xv(w2[18:17]);
			rdc(8'h14, 32'h1FFF, 32'h1E);
			rdc(8'h20, 32'hFFFFFF, {8'h0, w2});
			rdc(8'h24, 32'h7FFF, {17'h0, w1[16:2]});
			rdc(8'h2C, 32'hFFFFF, {15'h0, 17'(w2[16:0] + t)});
		end
		wrap_up();
	end
endmodule
